// ===== hw/cac_msg_ctrl.sv
// message object control, receive buffering and send scheduling
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "cac_defs.svh"
module cac_msg_ctrl
  import cac_pkg::*;
#(
  parameter int NUM_OBJ = `CAC_NUM_OBJ  // last object is double buffered
) (
  input  logic       clk_i,
  input  logic       rst_b_i,
  input  logic [7:0] addr_i,        // register address
  input  logic [7:0] wdata_i,       // register write data
  input  logic       we_i,          // write strobe
  input  logic       re_i,          // read strobe
  output logic [7:0] rdata_o,       // read data, cycle after re_i
  input  cac_rx_t    rx_i,          // frame from the protocol engine
  input  logic       rx_store_i,    // data frame received for rx_i.obj
  input  logic       rx_remote_i,   // remote frame received for rx_i.obj
  output cac_tx_t    tx_o,          // frame to send
  output logic       tx_valid_o,    // tx_o holds a frame to send
  input  logic       tx_done_i,     // engine finished sending tx_o
  output logic       irq_o          // object interrupt request
);

  localparam int NB = `CAC_NUM_BYTES;

  // the object number field is four bits wide
  if (NUM_OBJ < 2 || NUM_OBJ > 15) begin : g_bad_num
    $error("NUM_OBJ must be 2 to 15");
  end

  // address split: upper nibble object, lower nibble register
  logic [3:0] a_obj;
  logic [3:0] a_off;
  assign a_obj = addr_i[7:4];
  assign a_off = addr_i[3:0];

  // per object storage
  logic [7:0]  flag   [1:NUM_OBJ];  // stored flag bits
  logic [7:0]  hw_set [1:NUM_OBJ];  // hardware set per flag
  logic [7:0]  hw_clr [1:NUM_OBJ];  // hardware clear per flag
  logic [63:0] data_q [1:NUM_OBJ];  // host visible data bytes
  logic [3:0]  dlc_q  [1:NUM_OBJ];  // data length code
  logic [NUM_OBJ:1] dir_q;          // 1 = send object
  logic [NUM_OBJ:1] rmt_hw_q;       // remote frame seen, not yet answered
  logic [NUM_OBJ:1] cand;           // object wants the bus

  // second buffer of the last object
  logic [63:0] spare_data_q;
  logic [3:0]  spare_dlc_q;
  logic        spare_full_q;

  // controller wide state
  logic       gie_q;     // global_irq_enable
  cac_tx_st_t st_q;      // send scheduler state
  cac_obj_t   cur_q;     // object being sent
  cac_tx_t    tx_q;
  logic       tx_valid_q;
  logic       irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rd_d;
  cac_obj_t   pick;
  logic       any_cand;

  // turn four flags into the true/complement read image
  function automatic logic [7:0] pairs(input logic [3:0] f);
    pairs = {f[0], ~f[0], f[1], ~f[1], f[2], ~f[2], f[3], ~f[3]};
  endfunction

  for (genvar o = 1; o <= NUM_OBJ; o++) begin : g_obj
    logic sel;         // register access addresses this object
    logic wr_c0;       // write to object_control_low
    logic wr_c1;       // write to object_control_high
    logic rx_hit;      // data frame accepted
    logic rmt_hit;     // remote frame accepted
    logic done_hit;    // our transmission ended
    logic start_hit;   // our transmission starts now
    logic dbuf;        // this object has the spare buffer
    logic promote;     // host releases buffer, spare moves up
    logic to_spare;    // new frame lands in the spare buffer
    logic lost;        // a stored message is overwritten

    assign sel      = a_obj == 4'(o);
    assign wr_c0    = we_i && sel && a_off == `CAC_OFF_CON0;
    assign wr_c1    = we_i && sel && a_off == `CAC_OFF_CON1;
    assign dbuf     = o == NUM_OBJ;

    // only valid objects take part in traffic
    assign rx_hit   = rx_store_i && rx_i.obj == 4'(o) && flag[o][`CAC_F_VALID] && !dir_q[o];
    assign rmt_hit  = rx_remote_i && rx_i.obj == 4'(o) && flag[o][`CAC_F_VALID] && dir_q[o];
    assign done_hit = st_q == CAC_SEND && tx_done_i && cur_q == 4'(o);
    assign start_hit = st_q == CAC_IDLE && any_cand && pick == 4'(o);

    // last object: host still holds the first message
    assign to_spare = dbuf && rx_hit && flag[o][`CAC_F_FRESH];
    // host clears fresh_contents while a spare message waits
    assign promote  = dbuf && spare_full_q && wr_c1 && wdata_i[1:0] == `CAC_PAIR_CLR;
    // single buffer overwrite or third message on spare
    assign lost     = rx_hit && flag[o][`CAC_F_FRESH] && (!dbuf || spare_full_q);

    // bus request: software request, or unanswered remote frame
    // while software is not updating the contents
    assign cand[o] = flag[o][`CAC_F_VALID] &&
                     (flag[o][`CAC_F_TXRQ] ||
                      (rmt_hw_q[o] && dir_q[o] && !flag[o][`CAC_F_MLOST]));

    // hardware events per flag; enables have none
    assign hw_set[o][`CAC_F_VALID] = 1'b0;
    assign hw_set[o][`CAC_F_SNDEN] = 1'b0;
    assign hw_set[o][`CAC_F_RCVEN] = 1'b0;
    // pending rises regardless of global enable
    assign hw_set[o][`CAC_F_IPND]  = (done_hit && dir_q[o] && flag[o][`CAC_F_SNDEN]) ||
                                     ((rx_hit || promote) && flag[o][`CAC_F_RCVEN]);
    assign hw_set[o][`CAC_F_RREQ]  = rmt_hit;
    // request reads set from start to end of sending
    assign hw_set[o][`CAC_F_TXRQ]  = start_hit;
    assign hw_set[o][`CAC_F_MLOST] = lost && !dir_q[o];
    assign hw_set[o][`CAC_F_FRESH] = rx_hit || promote;
    assign hw_clr[o][`CAC_F_VALID] = 1'b0;
    assign hw_clr[o][`CAC_F_SNDEN] = 1'b0;
    assign hw_clr[o][`CAC_F_RCVEN] = 1'b0;
    assign hw_clr[o][`CAC_F_IPND]  = 1'b0;
    assign hw_clr[o][`CAC_F_RREQ]  = done_hit && dir_q[o];
    assign hw_clr[o][`CAC_F_TXRQ]  = done_hit;
    assign hw_clr[o][`CAC_F_MLOST] = 1'b0;
    assign hw_clr[o][`CAC_F_FRESH] = 1'b0;

    // eight pair fields, four per control register
    for (genvar k = 0; k < 8; k++) begin : g_flag
      cac_pair_flag u_flag (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .wr_i     (k < 4 ? wr_c0 : wr_c1),
        .pair_i   (wdata_i[7 - 2 * (k % 4) -: 2]),
        .hw_set_i (hw_set[o][k]),
        .hw_clr_i (hw_clr[o][k]),
        .flag_o   (flag[o][k])
      );
    end

    // remote frame memory; a software set of the visible flag
    // never reaches here, so it starts nothing
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        rmt_hw_q[o] <= 1'b0;
      end else if (rmt_hit) begin
        rmt_hw_q[o] <= 1'b1;
      end else if (done_hit) begin
        rmt_hw_q[o] <= 1'b0;
      end
    end

    // configuration, data bytes and received frames
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        data_q[o] <= '0;
        dlc_q[o]  <= '0;
        dir_q[o]  <= 1'b0;
      end else begin
        if (we_i && sel && a_off == `CAC_OFF_CFG) begin
          dlc_q[o] <= wdata_i[`CAC_CFG_DLC];
          dir_q[o] <= wdata_i[`CAC_CFG_DIR];
        end
        // software fills send data byte by byte
        for (int b = 0; b < NB; b++) begin
          if (we_i && sel && a_off == 4'(`CAC_OFF_DATA0 + b)) begin
            data_q[o][8*b +: 8] <= wdata_i;
          end
        end
        // all eight bytes are taken even past dlc, so unused
        // bytes change with traffic
        if (rx_hit && !to_spare) begin
          data_q[o] <= rx_i.data;
          dlc_q[o]  <= rx_i.dlc;
        end else if (promote) begin
          data_q[o] <= spare_data_q;
          dlc_q[o]  <= spare_dlc_q;
        end
      end
    end

    // the spare buffer exists on the last object only
    if (o == NUM_OBJ) begin : g_spare
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          spare_data_q <= '0;
          spare_dlc_q  <= '0;
          spare_full_q <= 1'b0;
        end else begin
          if (to_spare) begin
            // a full spare is simply overwritten
            spare_data_q <= rx_i.data;
            spare_dlc_q  <= rx_i.dlc;
            spare_full_q <= 1'b1;
          end else if (promote) begin
            spare_full_q <= 1'b0;
          end
        end
      end
    end
  end

  // lowest numbered candidate wins the bus
  always_comb begin
    pick     = '0;
    any_cand = 1'b0;
    for (int i = NUM_OBJ; i >= 1; i--) begin
      if (cand[i]) begin
        pick     = 4'(i);
        any_cand = 1'b1;
      end
    end
  end

  // send scheduler; frame is copied so later data writes
  // cannot tear a frame that is already on the bus
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q       <= CAC_IDLE;
      cur_q      <= '0;
      tx_q       <= '0;
      tx_valid_q <= 1'b0;
    end else begin
      unique case (st_q)
        CAC_IDLE: begin
          if (any_cand) begin
            st_q        <= CAC_SEND;
            cur_q       <= pick;
            tx_q.obj    <= pick;
            tx_q.remote <= !dir_q[pick];
            tx_q.dlc    <= dlc_q[pick];
            tx_q.data   <= data_q[pick];
            tx_valid_q  <= 1'b1;
          end
        end
        CAC_SEND: begin
          // the engine retries on its own until it reports done
          if (tx_done_i) begin
            st_q       <= CAC_IDLE;
            tx_valid_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // global_irq_enable in the controller_control register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gie_q <= 1'b0;
    end else if (we_i && addr_i == `CAC_ADDR_CTRL) begin
      gie_q <= wdata_i[`CAC_GIE_BIT];
    end
  end

  // request leaves only when globally enabled
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      for (int i = 1; i <= NUM_OBJ; i++) begin
        if (flag[i][`CAC_F_IPND] && gie_q) begin
          irq_q <= 1'b1;
        end
      end
    end
  end

  // read image; unmapped addresses read zero
  always_comb begin
    rd_d = '0;
    if (addr_i == `CAC_ADDR_CTRL) begin
      rd_d[`CAC_GIE_BIT] = gie_q;
    end else if (a_obj >= 4'h1 && a_obj <= 4'(NUM_OBJ)) begin
      if (a_off == `CAC_OFF_CON0) begin
        rd_d = pairs(flag[a_obj][3:0]);
      end else if (a_off == `CAC_OFF_CON1) begin
        rd_d = pairs(flag[a_obj][7:4]);
      end else if (a_off == `CAC_OFF_CFG) begin
        rd_d[`CAC_CFG_DLC] = dlc_q[a_obj];
        rd_d[`CAC_CFG_DIR] = dir_q[a_obj];
      end else if (a_off >= `CAC_OFF_DATA0 && a_off < 4'(`CAC_OFF_DATA0 + NB)) begin
        rd_d = data_q[a_obj][8*(a_off - `CAC_OFF_DATA0) +: 8];
      end
    end
  end

  // read data stands for exactly one cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (re_i) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o    = rdata_q;
  assign tx_o       = tx_q;
  assign tx_valid_o = tx_valid_q;
  assign irq_o      = irq_q;
endmodule

// ===== hw/cac_defs.svh
// constants of the message object control block
// How it works
// - each flag shown as true/complement pair
// - write 10 sets, 01 clears, 11 keeps
// - write 00 forbidden; reads give 10/01
// - only valid objects are sent or received
// - send done sets pending if send enabled
// - receive done sets pending if receive enabled
// - hardware sets pending; software clears it
// - remote frame marks send object remote pending
// - remote pending and not updating: send, clear
// - software remote pending alone starts nothing
// - request: receive object remote, send object data
// - request reads set until transmission ends
// - objects below last: one buffer, overwrite
// - last object has two alternating buffers
// - third message overwrites the second one
// - zero to eight data bytes per object
// - unused data bytes may change anytime
// - host updating blocks remote frame answer
// - store while fresh set marks overwritten; last object only with spare full
// - each store sets fresh contents
// - global enable off: pending set, no irq
`ifndef CAC_DEFS_SVH
`define CAC_DEFS_SVH
`define CAC_NUM_OBJ    15
`define CAC_NUM_BYTES  8
`define CAC_ADDR_CTRL  8'h00
`define CAC_GIE_BIT    1
`define CAC_OFF_CON0   4'h0
`define CAC_OFF_CON1   4'h1
`define CAC_OFF_CFG    4'h2
`define CAC_OFF_DATA0  4'h3
`define CAC_CFG_DLC    7:4
`define CAC_CFG_DIR    3
`define CAC_PAIR_SET   2'b10
`define CAC_PAIR_CLR   2'b01
`define CAC_F_VALID    0
`define CAC_F_SNDEN    1
`define CAC_F_RCVEN    2
`define CAC_F_IPND     3
`define CAC_F_RREQ     4
`define CAC_F_TXRQ     5
`define CAC_F_MLOST    6
`define CAC_F_FRESH    7
`endif

// ===== hw/cac_pkg.sv
// types shared by the message object control block
package cac_pkg;
  typedef logic [3:0] cac_obj_t;   // object number, 1 based
  // frame handed up by the protocol engine
  typedef struct packed {
    cac_obj_t    obj;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cac_rx_t;
  // frame handed down to the protocol engine
  typedef struct packed {
    cac_obj_t    obj;
    logic        remote;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cac_tx_t;
  // transmit scheduler states
  typedef enum logic {CAC_IDLE, CAC_SEND} cac_tx_st_t;
endpackage

// ===== hw/cac_pair_flag.sv
// one flag of an object control register, stored as a single bit
`timescale 1ns/1ps
module cac_pair_flag (
  input  logic       clk_i,
  input  logic       rst_b_i,
  input  logic       wr_i,      // byte write hits this register
  input  logic [1:0] pair_i,    // the two write bits of this field
  input  logic       hw_set_i,  // hardware event sets the flag
  input  logic       hw_clr_i,  // hardware event clears the flag
  output logic       flag_o     // stored true form
);
  `include "cac_defs.svh"
  logic flag_q;  // the only storage; complement is derived on read
  logic flag_d;

  // sets are applied last so an event is never lost to a clear
  always_comb begin
    flag_d = flag_q;
    if (hw_clr_i) begin
      flag_d = 1'b0;
    end
    if (wr_i && pair_i == `CAC_PAIR_CLR) begin
      flag_d = 1'b0;
    end
    if (wr_i && pair_i == `CAC_PAIR_SET) begin
      flag_d = 1'b1;
    end
    // 11 keeps; 00 is forbidden and is treated as
    if (hw_set_i) begin
      flag_d = 1'b1;
    end
  end

  // single stored bit per field
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
endmodule

// ===== tb/cac_msg_ctrl_asserts.sv
// port checker for the message object control block
`timescale 1ns/1ps
module cac_msg_ctrl_asserts
  import cac_pkg::*;
#(
  parameter int NUM_OBJ = 15  // highest object served
) (
  input logic       clk_i,
  input logic       rst_b_i,
  input logic [7:0] addr_i,
  input logic [7:0] wdata_i,
  input logic       we_i,
  input logic       re_i,
  input logic [7:0] rdata_o,
  input cac_rx_t    rx_i,
  input logic       rx_store_i,
  input logic       rx_remote_i,
  input cac_tx_t    tx_o,
  input logic       tx_valid_o,
  input logic       tx_done_i,
  input logic       irq_o
);
  logic gie_q;   // mirror of the global enable bit
  logic ctl_rd;  // read of a control register of a real object
  // mirror the global enable; only software ever writes it
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gie_q <= 1'b0;
    end else if (we_i && addr_i == 8'h00) begin
      gie_q <= wdata_i[1];
    end
  end
  assign ctl_rd = re_i && addr_i[3:1] == 3'h0 && addr_i[7:4] != 4'h0 && int'(addr_i[7:4]) <= NUM_OBJ;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // a frame finishing on the bus
  sequence s_done;
    tx_valid_o && tx_done_i;
  endsequence
  a_rdata_quiet: assert property (!re_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_pair_form: assert property (ctl_rd |=> &({rdata_o[7], rdata_o[5], rdata_o[3], rdata_o[1]}
    ^ {rdata_o[6], rdata_o[4], rdata_o[2], rdata_o[0]})) else $error("pair read not 10 or 01");
  a_ctrl_read: assert property (re_i && addr_i == 8'h00 |=> rdata_o[1] == gie_q)
    else $error("global enable reads wrong");
  a_tx_hold: assert property (tx_valid_o && !tx_done_i |=> tx_valid_o && $stable(tx_o))
    else $error("frame dropped or changed before done");
  a_tx_drop: assert property (s_done |=> !tx_valid_o)
    else $error("frame still offered after done");
  a_tx_cause: assert property ($fell(tx_valid_o) |-> $past(tx_done_i))
    else $error("frame withdrawn without done");
  a_tx_obj: assert property (tx_valid_o |-> tx_o.obj != 4'h0 && int'(tx_o.obj) <= NUM_OBJ)
    else $error("frame from no object");
  a_irq_gated: assert property (irq_o |-> $past(gie_q))
    else $error("irq with global enable off");
  a_irq_off: assert property (we_i && addr_i == 8'h00 && !wdata_i[1] |=> ##1 !irq_o)
    else $error("irq stays after global disable");
endmodule

// ===== tb/cac_engine_model.sv
// protocol engine stand-in: finishes offered frames and injects heard ones
`timescale 1ns/1ps
module cac_engine_model
  import cac_pkg::*;
(
  input  logic    clk_i,
  input  logic    rst_b_i,
  input  cac_tx_t tx_i,        // frame offered by the block
  input  logic    tx_valid_i,  // a frame is offered
  output logic    tx_done_o,   // frame finished on the bus
  output cac_rx_t rx_o,        // frame heard on the bus
  output logic    store_o,     // data frame heard
  output logic    remote_o     // remote frame heard
);
  int      lat = 3;   // bus time of a frame, set by the bench
  int      sent = 0;  // frames finished
  int      cnt = 0;   // cycles spent on the current frame
  cac_tx_t last;      // last finished frame
  initial begin
    rx_o = '0;
    store_o = 1'b0;
    remote_o = 1'b0;
  end
  // done is a one cycle pulse; count restarts so a held frame is not sent twice
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_done_o <= 1'b0;
      cnt <= 0;
    end else if (tx_done_o) begin
      tx_done_o <= 1'b0;
      cnt <= 0;
    end else if (tx_valid_i) begin
      if (cnt >= lat) begin
        tx_done_o <= 1'b1;
        last <= tx_i;
        sent <= sent + 1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
  // one heard frame of eight bytes; afterwards the lines carry scrambled values
  task automatic hear(input cac_obj_t o, input logic [7:0] b, input logic rem);
    @(posedge clk_i);
    rx_o <= '{obj: o, dlc: 4'h8, data: {8{b}}};
    store_o <= !rem;
    remote_o <= rem;
    @(posedge clk_i);
    store_o <= 1'b0;
    remote_o <= 1'b0;
    rx_o <= ~rx_o;
  endtask
endmodule

// ===== tb/cac_msg_ctrl_tb_top.sv
// bench for the message object control block
`timescale 1ns/1ps
module cac_msg_ctrl_tb_top
  import cac_pkg::*;
;
  logic       clk_i = 1'b0;    // 200 MHz clock
  logic       rst_b_i = 1'b0;  // held low at start
  logic [7:0] addr_i = 8'h00;  // register address
  logic [7:0] wdata_i = 8'h00; // register write data
  logic       we_i = 1'b0;     // write strobe
  logic       re_i = 1'b0;     // read strobe
  logic [7:0] rdata_o;
  cac_rx_t    rx_i;
  cac_tx_t    tx_o;
  logic       rx_store_i, rx_remote_i, tx_valid_o, tx_done_i, irq_o;
  int         errors = 0;
  int         n_tests = 0;
  int         i;
  always #2.5 clk_i = ~clk_i;
  cac_msg_ctrl u_cac_msg_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .rx_i(rx_i), .rx_store_i(rx_store_i),
    .rx_remote_i(rx_remote_i), .tx_o(tx_o), .tx_valid_o(tx_valid_o), .tx_done_i(tx_done_i), .irq_o(irq_o));
  cac_engine_model u_cac_engine_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_i(tx_o),
    .tx_valid_i(tx_valid_o), .tx_done_o(tx_done_i), .rx_o(rx_i), .store_o(rx_store_i), .remote_o(rx_remote_i));
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // address of a register of an object
  function automatic logic [7:0] ad(input int o, input logic [3:0] f);
    return {4'(o), f};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, e);
  endtask
  // bounded wait for the engine to finish frame number n
  task automatic wait_sent(input int n);
    for (int k = 0; k < 80 && u_cac_engine_model.sent != n; k++) @(posedge clk_i);
    if (u_cac_engine_model.sent != n) begin
      errors++;
      $display("BAD %0t frame never finished", $time);
      report_and_stop();
    end
  endtask
  // objects here never share an identifier
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(ad(1, 0), 8'h55);
    rd(ad(1, 1), 8'h55);
    rd(8'h00, 8'h00);
    wr(ad(1, 4'hf), 8'h12);
    rd(ad(1, 4'hf), 8'h00);
    for (i = 1; i <= 15; i++) wr(ad(i, 0), 8'h7f);
    wr(ad(1, 0), 8'hbf);
    rd(ad(1, 0), 8'h95);
    wr(ad(1, 0), 8'hef);
    rd(ad(1, 0), 8'ha5);
    wr(ad(1, 0), 8'h7f);
    rd(ad(1, 0), 8'h65);
    u_cac_engine_model.hear(2, 8'h11, 1'b0);
    rd(ad(2, 1), 8'h55);
    wr(ad(2, 0), 8'hbb);
    u_cac_engine_model.hear(2, 8'h22, 1'b0);
    rd(ad(2, 1), 8'h56);
    rd(ad(2, 0), 8'h9a);
    rd(ad(2, 4'ha), 8'h22);
    rd(ad(2, 2), 8'h80);
    u_cac_engine_model.hear(2, 8'h33, 1'b0);
    rd(ad(2, 1), 8'h5a);
    rd(ad(2, 3), 8'h33);
    chk({7'h0, irq_o}, 8'h00);
    wr(8'h00, 8'h02);
    repeat (3) @(negedge clk_i);
    chk({7'h0, irq_o}, 8'h01);
    wr(ad(2, 0), 8'hfd);
    repeat (3) @(negedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    rd(8'h00, 8'h02);
    wr(ad(15, 0), 8'hbf);
    u_cac_engine_model.hear(15, 8'ha1, 1'b0);
    u_cac_engine_model.hear(15, 8'hb2, 1'b0);
    rd(ad(15, 1), 8'h56);
    u_cac_engine_model.hear(15, 8'hc3, 1'b0);
    rd(ad(15, 1), 8'h5a);
    rd(ad(15, 3), 8'ha1);
    wr(ad(15, 1), 8'hfd);
    rd(ad(15, 3), 8'hc3);
    wr(ad(3, 2), 8'h28);
    wr(ad(3, 3), 8'h5a);
    wr(ad(3, 0), 8'haf);
    u_cac_engine_model.lat = 6;
    wr(ad(3, 1), 8'hef);
    rd(ad(3, 1), 8'h65);
    wait_sent(1);
    rd(ad(3, 1), 8'h55);
    rd(ad(3, 0), 8'ha6);
    chk({3'h0, u_cac_engine_model.last.remote, u_cac_engine_model.last.obj}, 8'h03);
    chk(u_cac_engine_model.last.data[7:0], 8'h5a);
    chk({4'h0, u_cac_engine_model.last.dlc}, 8'h02);
    u_cac_engine_model.lat = 0;
    wr(ad(2, 1), 8'hef);
    wait_sent(2);
    chk({3'h0, u_cac_engine_model.last.remote, u_cac_engine_model.last.obj}, 8'h12);
    wr(ad(3, 1), 8'hfb);
    u_cac_engine_model.hear(3, 8'h00, 1'b1);
    rd(ad(3, 1), 8'h99);
    repeat (10) @(negedge clk_i);
    chk(8'(u_cac_engine_model.sent), 8'h02);
    wr(ad(3, 1), 8'hf7);
    wait_sent(3);
    rd(ad(3, 1), 8'h55);
    chk({3'h0, u_cac_engine_model.last.remote, u_cac_engine_model.last.obj}, 8'h03);
    wr(ad(3, 1), 8'hbf);
    wr(ad(1, 1), 8'hef);
    repeat (10) @(negedge clk_i);
    chk(8'(u_cac_engine_model.sent), 8'h03);
    rd(ad(3, 1), 8'h95);
    chk({7'h0, irq_o}, 8'h01);
    wr(8'h00, 8'h00);
    repeat (3) @(negedge clk_i);
    chk({7'h0, irq_o}, 8'h00);
    report_and_stop();
  end
endmodule
bind cac_msg_ctrl cac_msg_ctrl_asserts #(.NUM_OBJ(NUM_OBJ)) u_cac_msg_ctrl_asserts (.clk_i(clk_i),
  .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
  .rx_i(rx_i), .rx_store_i(rx_store_i), .rx_remote_i(rx_remote_i), .tx_o(tx_o), .tx_valid_o(tx_valid_o),
  .tx_done_i(tx_done_i), .irq_o(irq_o));
